// ==== flg_consts.svh ====
// Constants of the fault-protect and loop-gain block: command codes, field positions, resets.
// Assumes measurement codes arrive already digitized, one set per switching cycle.
`ifndef FLG_CONSTS_SVH
`define FLG_CONSTS_SVH
`define FLG_CMD_VOUT_OV_FLT 8'h40
`define FLG_CMD_VOUT_OV_WRN 8'h42
`define FLG_CMD_VOUT_UV_WRN 8'h43
`define FLG_CMD_VOUT_UV_FLT 8'h44
`define FLG_CMD_IOUT_OC_WRN 8'h4A
`define FLG_CMD_IOUT_UC_WRN 8'h4B
`define FLG_CMD_OT_FLT 8'h4F
`define FLG_CMD_OT_RESP 8'h50
`define FLG_CMD_OT_WRN 8'h51
`define FLG_CMD_UT_WRN 8'h52
`define FLG_CMD_UT_FLT 8'h53
`define FLG_CMD_UT_RESP 8'h54
`define FLG_CMD_VIN_OV_FLT 8'h55
`define FLG_CMD_VIN_OV_RESP 8'h56
`define FLG_CMD_VIN_OV_WRN 8'h57
`define FLG_CMD_VIN_UV_WRN 8'h58
`define FLG_CMD_VIN_UV_FLT 8'h59
`define FLG_CMD_VIN_UV_RESP 8'h5A
`define FLG_CMD_VOUT_OV_RESP 8'h41
`define FLG_CMD_VOUT_UV_RESP 8'h45
`define FLG_CMD_GAIN_RED 8'hD5
`define FLG_CMD_LOOP_GAIN 8'hDF
`define FLG_CMD_OC_RESP 8'hE5
`define FLG_CMD_RC_RESP 8'hE6
`define FLG_CMD_AVG_OC_LIM 8'hE7
`define FLG_CMD_AVG_RC_LIM 8'hE8
`define FLG_CMD_STATUS_BYTE 8'h78
`define FLG_CMD_STATUS_WORD 8'h79
`define FLG_CMD_STATUS_VOUT 8'h7A
`define FLG_CMD_STATUS_IOUT 8'h7B
`define FLG_CMD_STATUS_INPUT 8'h7C
`define FLG_CMD_STATUS_TEMP 8'h7D
`define FLG_CMD_READ_VIN 8'h88
`define FLG_CMD_READ_VOUT 8'h8B
`define FLG_CMD_READ_IOUT 8'h8C
`define FLG_CMD_READ_TEMP 8'h8D
`define FLG_AVG_OC_RST 16'sh0065
`define FLG_AVG_RC_RST 16'shFF9D
`define FLG_OC_CYCLES 5'h0F
`define FLG_PGAIN_RST 16'h010E
`define FLG_IGAIN_RST 8'h50
`define FLG_RGAIN_RST 8'h50
`define FLG_LIM_MAX 16'sh7FFF
`define FLG_LIM_MIN 16'sh8000
`define FLG_RESP_RST 8'h03
`define FLG_GRED_RST 16'h0000
`define FLG_THR_LSB 0
`define FLG_SHIFT_LSB 12
`define FLG_PG_LSB 0
`define FLG_RG_LSB 16
`define FLG_IG_LSB 24
`define FLG_RESP_REPORT 1
`define FLG_RESP_INHIBIT 0
`endif

// ==== flg_fault_loop.sv ====
// Supervisory comparators, current trips, alert and three-term loop correction.
// Assumes one measurement strobe per switching cycle and a single-cycle command port.
`timescale 1ns/10ps
`include "flg_consts.svh"
// What this block does
// - Inhibit conversion outside input fault limits.
// - Compare output voltage each cycle against limits.
// - Mask undervoltage fault until power good.
// - Overcurrent trip after over 15 cycles.
// - Reverse current trip below minus 99A.
// - Instant current limit far above average.
// - Programmable current warnings and trip responses.
// - Temperature warnings, faults, separate responses.
// - Raise alert on any reporting fault.
// - Return status and telemetry on reads.
// - Proportional gain scales error into correction.
// - Integral gain from top configuration byte.
// - Residual gain acts one cycle later.
// - Reduce gain while error stays low.
// - Restore full gain same cycle.
// - Proportional gain resets to 270.
// - Integral and residual gains reset to 80.
module flg_fault_loop import flg_pkg::*; #(
  parameter int LOW_ERR_CYCLES = 64,
  parameter logic signed [15:0] PEAK_LIMIT = 16'sh00C8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cycle_i,
  input wire flg_meas_s meas_i,
  input wire logic signed [15:0] err_i,
  input wire logic signed [15:0] inst_cur_i,
  input wire logic power_good_pin_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic cmd_ack_o,
  output logic inhibit_o,
  output logic alert_o,
  output logic signed [31:0] pw_corr_o
);
  // Outside these bounds the low-error counter overflows or normal current trips the peak.
  if (LOW_ERR_CYCLES < 2 || LOW_ERR_CYCLES > 65535) begin : g_bad_low_err
    $error("LOW_ERR_CYCLES out of range.");
  end
  if (PEAK_LIMIT <= `FLG_AVG_OC_RST) begin : g_bad_peak
    $error("PEAK_LIMIT must lie above the average limit.");
  end

  function automatic flg_cmp_s cmp4(input logic signed [15:0] v, input logic signed [15:0] ovf,
      input logic signed [15:0] ovw, input logic signed [15:0] uvw,
      input logic signed [15:0] uvf);
    cmp4.ov_flt = v > ovf;
    cmp4.ov_wrn = v > ovw;
    cmp4.uv_wrn = v < uvw;
    cmp4.uv_flt = v < uvf;
  endfunction

  // Signed error times an unsigned gain field, kept to the correction width.
  function automatic logic signed [31:0] scale(input logic signed [15:0] v,
      input logic [15:0] g);
    scale = 32'(v * $signed({1'b0, g}));
  endfunction

  // Write-one-to-clear merge; the event is ORed last so a same-cycle event wins.
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic clr,
      input logic [7:0] mask, input logic [7:0] ev);
    w1c = (cur & ~(clr ? mask : 8'h00)) | ev;
  endfunction

  logic signed [15:0] vin_ovf_q, vin_ovw_q, vin_uvw_q, vin_uvf_q;
  logic signed [15:0] vo_ovf_q, vo_ovw_q, vo_uvw_q, vo_uvf_q;
  logic signed [15:0] oc_wrn_q, uc_wrn_q, avg_oc_q, avg_rc_q;
  logic signed [15:0] ot_f_q, ot_w_q, ut_w_q, ut_f_q;
  logic [7:0] vin_ov_rsp_q, vin_uv_rsp_q, vo_ov_rsp_q, vo_uv_rsp_q;
  logic [7:0] oc_rsp_q, rc_rsp_q, ot_rsp_q, ut_rsp_q;
  logic [31:0] loop_gain_config_q;
  logic [15:0] gain_reduction_config_q;

  // Limit and configuration registers written by the host.
  // Status codes are not stored here; a write to the VOUT, IOUT, INPUT or TEMP status code clears its sticky bits further down.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vin_ovf_q <= `FLG_LIM_MAX;
      vin_ovw_q <= `FLG_LIM_MAX;
      vin_uvw_q <= `FLG_LIM_MIN;
      vin_uvf_q <= `FLG_LIM_MIN;
      vo_ovf_q <= `FLG_LIM_MAX;
      vo_ovw_q <= `FLG_LIM_MAX;
      vo_uvw_q <= `FLG_LIM_MIN;
      vo_uvf_q <= `FLG_LIM_MIN;
      oc_wrn_q <= `FLG_LIM_MAX;
      uc_wrn_q <= `FLG_LIM_MIN;
      avg_oc_q <= `FLG_AVG_OC_RST;
      avg_rc_q <= `FLG_AVG_RC_RST;
      ot_f_q <= `FLG_LIM_MAX;
      ot_w_q <= `FLG_LIM_MAX;
      ut_w_q <= `FLG_LIM_MIN;
      ut_f_q <= `FLG_LIM_MIN;
      vin_ov_rsp_q <= `FLG_RESP_RST;
      vin_uv_rsp_q <= `FLG_RESP_RST;
      vo_ov_rsp_q <= `FLG_RESP_RST;
      vo_uv_rsp_q <= `FLG_RESP_RST;
      oc_rsp_q <= `FLG_RESP_RST;
      rc_rsp_q <= `FLG_RESP_RST;
      ot_rsp_q <= `FLG_RESP_RST;
      ut_rsp_q <= `FLG_RESP_RST;
      loop_gain_config_q <= {`FLG_IGAIN_RST, `FLG_RGAIN_RST,
          `FLG_PGAIN_RST};
      gain_reduction_config_q <= `FLG_GRED_RST;
    end else if (cmd_wr_i) begin
      case (cmd_code_i)
        `FLG_CMD_VIN_OV_FLT: vin_ovf_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VIN_OV_WRN: vin_ovw_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VIN_UV_WRN: vin_uvw_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VIN_UV_FLT: vin_uvf_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VIN_OV_RESP: vin_ov_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_VIN_UV_RESP: vin_uv_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_VOUT_OV_FLT: vo_ovf_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VOUT_OV_WRN: vo_ovw_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VOUT_UV_WRN: vo_uvw_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VOUT_UV_FLT: vo_uvf_q <= cmd_wdata_i[15:0];
        `FLG_CMD_VOUT_OV_RESP: vo_ov_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_VOUT_UV_RESP: vo_uv_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_IOUT_OC_WRN: oc_wrn_q <= cmd_wdata_i[15:0];
        `FLG_CMD_IOUT_UC_WRN: uc_wrn_q <= cmd_wdata_i[15:0];
        `FLG_CMD_OC_RESP: oc_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_RC_RESP: rc_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_AVG_OC_LIM: avg_oc_q <= cmd_wdata_i[15:0];
        `FLG_CMD_AVG_RC_LIM: avg_rc_q <= cmd_wdata_i[15:0];
        `FLG_CMD_OT_FLT: ot_f_q <= cmd_wdata_i[15:0];
        `FLG_CMD_OT_WRN: ot_w_q <= cmd_wdata_i[15:0];
        `FLG_CMD_UT_WRN: ut_w_q <= cmd_wdata_i[15:0];
        `FLG_CMD_UT_FLT: ut_f_q <= cmd_wdata_i[15:0];
        `FLG_CMD_OT_RESP: ot_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_UT_RESP: ut_rsp_q <= cmd_wdata_i[7:0];
        `FLG_CMD_LOOP_GAIN: loop_gain_config_q <= cmd_wdata_i;
        `FLG_CMD_GAIN_RED: gain_reduction_config_q <= cmd_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Power good comes from another clock domain of the power stage, so it is filtered.
  logic [2:0] pg_sync_q;
  logic pg_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_sync_q <= 3'b000;
      pg_q <= 1'b0;
    end else begin
      pg_sync_q <= {pg_sync_q[1:0], power_good_pin_i};
      if (pg_sync_q[1] == pg_sync_q[2]) begin
        pg_q <= pg_sync_q[2];
      end
    end
  end

  flg_cmp_s vin_c, vo_c, tmp_c;
  assign vin_c = cmp4(meas_i.vin, vin_ovf_q, vin_ovw_q, vin_uvw_q, vin_uvf_q);
  assign vo_c = cmp4(meas_i.vout, vo_ovf_q, vo_ovw_q, vo_uvw_q, vo_uvf_q);
  assign tmp_c = cmp4(meas_i.temp, ot_f_q, ot_w_q, ut_w_q, ut_f_q);

  // Average overcurrent run length saturates so it never wraps back to a quiet value.
  logic [4:0] oc_cnt_q;
  logic oc_trip, rc_trip, peak_trip;
  assign oc_trip = cycle_i && meas_i.iout > avg_oc_q && oc_cnt_q >= `FLG_OC_CYCLES;
  assign rc_trip = cycle_i && meas_i.iout < avg_rc_q;
  // The instant limit sits well above the average one; even a one-clock peak above it trips, with no strobe needed.
  assign peak_trip = inst_cur_i > PEAK_LIMIT;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_cnt_q <= 5'h00;
    end else if (cycle_i) begin
      if (meas_i.iout <= avg_oc_q) begin
        oc_cnt_q <= 5'h00;
      end else if (oc_cnt_q != 5'h1F) begin
        oc_cnt_q <= oc_cnt_q + 5'h01;
      end
    end
  end

  // Sticky status; a detected event wins over a clear in the same cycle.
  logic [7:0] st_vout_q, st_iout_q, st_in_q, st_tmp_q;
  logic [7:0] ev_vout, ev_iout, ev_in, ev_tmp;
  logic clr_vout, clr_iout, clr_in, clr_tmp;
  assign ev_vout = cycle_i ? {vo_c.ov_flt, vo_c.ov_wrn, vo_c.uv_wrn,
      vo_c.uv_flt && pg_q, 4'h0} : 8'h00;
  assign ev_iout = {oc_trip || peak_trip, 1'b0,
      cycle_i && meas_i.iout > oc_wrn_q, rc_trip, cycle_i && meas_i.iout < uc_wrn_q, 3'h0};
  assign ev_in = cycle_i ? {vin_c.ov_flt, vin_c.ov_wrn, vin_c.uv_wrn, vin_c.uv_flt, 4'h0} : 8'h00;
  assign ev_tmp = cycle_i ? {tmp_c.ov_flt, tmp_c.ov_wrn, tmp_c.uv_wrn, tmp_c.uv_flt, 4'h0} : 8'h00;
  assign clr_vout = cmd_wr_i && cmd_code_i == `FLG_CMD_STATUS_VOUT;
  assign clr_iout = cmd_wr_i && cmd_code_i == `FLG_CMD_STATUS_IOUT;
  assign clr_in = cmd_wr_i && cmd_code_i == `FLG_CMD_STATUS_INPUT;
  assign clr_tmp = cmd_wr_i && cmd_code_i == `FLG_CMD_STATUS_TEMP;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_vout_q <= 8'h00;
      st_iout_q <= 8'h00;
      st_in_q <= 8'h00;
      st_tmp_q <= 8'h00;
    end else begin
      st_vout_q <= w1c(st_vout_q, clr_vout, cmd_wdata_i[7:0], ev_vout);
      st_iout_q <= w1c(st_iout_q, clr_iout, cmd_wdata_i[7:0], ev_iout);
      st_in_q <= w1c(st_in_q, clr_in, cmd_wdata_i[7:0], ev_in);
      st_tmp_q <= w1c(st_tmp_q, clr_tmp, cmd_wdata_i[7:0], ev_tmp);
    end
  end

  // Each fault reports on the alert when bit 1 of its response is set; bit 0 inhibits, except for the two input faults.
  logic [7:0] flt_vec, rsp_rep, rsp_inh;
  assign flt_vec = {st_in_q[7], st_in_q[4], st_vout_q[7], st_vout_q[4],
      st_iout_q[7], st_iout_q[4], st_tmp_q[7], st_tmp_q[4]};
  assign rsp_rep = {vin_ov_rsp_q[`FLG_RESP_REPORT], vin_uv_rsp_q[`FLG_RESP_REPORT],
      vo_ov_rsp_q[`FLG_RESP_REPORT], vo_uv_rsp_q[`FLG_RESP_REPORT],
      oc_rsp_q[`FLG_RESP_REPORT], rc_rsp_q[`FLG_RESP_REPORT],
      ot_rsp_q[`FLG_RESP_REPORT], ut_rsp_q[`FLG_RESP_REPORT]};
  assign rsp_inh = {vin_ov_rsp_q[`FLG_RESP_INHIBIT], vin_uv_rsp_q[`FLG_RESP_INHIBIT],
      vo_ov_rsp_q[`FLG_RESP_INHIBIT], vo_uv_rsp_q[`FLG_RESP_INHIBIT],
      oc_rsp_q[`FLG_RESP_INHIBIT], rc_rsp_q[`FLG_RESP_INHIBIT],
      ot_rsp_q[`FLG_RESP_INHIBIT], ut_rsp_q[`FLG_RESP_INHIBIT]};
  // Alert is registered from the sticky bits and inhibit from them and in_bad_q, so both lag their sources by one clock.
  logic in_bad_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_bad_q <= 1'b1;
      inhibit_o <= 1'b1;
      alert_o <= 1'b0;
    end else begin
      if (cycle_i) begin
        in_bad_q <= vin_c.ov_flt || vin_c.uv_flt;
      end
      inhibit_o <= in_bad_q || |(flt_vec[5:0] & rsp_inh[5:0]);
      alert_o <= |(flt_vec & rsp_rep);
    end
  end

  // Gain reduction: error must stay at or under threshold a whole period before dividing.
  logic [15:0] low_cnt_q;
  logic red_q, err_big;
  logic [15:0] abs_err;
  // The most negative error maps to 16'h8000, which still counts as a large error.
  assign abs_err = err_i[15] ? 16'(-err_i) : err_i;
  assign err_big = abs_err > {4'h0, gain_reduction_config_q[`FLG_THR_LSB +: 12]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_q <= 16'h0000;
      red_q <= 1'b0;
    end else if (cycle_i) begin
      if (err_big) begin
        low_cnt_q <= 16'h0000;
        red_q <= 1'b0;
      end else if (low_cnt_q == 16'(LOW_ERR_CYCLES - 1)) begin
        red_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
    end
  end

  // Full gain comes back combinationally in the cycle the error exceeds the threshold.
  logic [15:0] pgain_eff;
  assign pgain_eff = (red_q && !err_big) ?
      (loop_gain_config_q[`FLG_PG_LSB +: 16] >> gain_reduction_config_q[`FLG_SHIFT_LSB +: 2]) :
      loop_gain_config_q[`FLG_PG_LSB +: 16];

  // Three-term correction; the integrator is unclamped and wraps at 32 bits, a known trade against windup range.
  logic signed [31:0] p_term, r_term, integ_q, dev_q, corr;
  logic [15:0] igain;
  assign igain = {8'h00, loop_gain_config_q[`FLG_IG_LSB +: 8]};
  assign p_term = scale(err_i, pgain_eff);
  assign r_term = 32'((dev_q * $signed({1'b0, loop_gain_config_q[`FLG_RG_LSB +: 8]})) >>> 8);
  assign corr = p_term + integ_q - r_term;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      integ_q <= 32'sh0;
      dev_q <= 32'sh0;
      pw_corr_o <= 32'sh0;
    end else if (cycle_i) begin
      integ_q <= integ_q + scale(err_i, igain);
      dev_q <= corr;
      pw_corr_o <= corr;
    end
  end

  // Telemetry latched once per cycle so reads see a coherent set.
  flg_meas_s tel_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tel_q <= '0;
    end else if (cycle_i) begin
      tel_q <= meas_i;
    end
  end

  logic [7:0] sbyte;
  assign sbyte = {1'b0, inhibit_o, st_vout_q[7], st_iout_q[7], st_in_q[4],
      |st_tmp_q, 2'b00};
  flg_cmd_e cst_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cst_q <= FLG_IDLE;
      cmd_rdata_o <= 32'h0;
      cmd_rvalid_o <= 1'b0;
      cmd_ack_o <= 1'b0;
    end else begin
      cmd_ack_o <= cmd_wr_i;
      cmd_rvalid_o <= 1'b0;
      case (cst_q)
        FLG_IDLE: if (cmd_rd_i) begin
          cst_q <= FLG_ANS;
          case (cmd_code_i)
            `FLG_CMD_STATUS_BYTE: cmd_rdata_o <= {24'h0, sbyte};
            `FLG_CMD_STATUS_WORD: cmd_rdata_o <= {16'h0, |st_vout_q, |st_iout_q,
                |st_in_q, 5'h0, sbyte};
            `FLG_CMD_STATUS_VOUT: cmd_rdata_o <= {24'h0, st_vout_q};
            `FLG_CMD_STATUS_IOUT: cmd_rdata_o <= {24'h0, st_iout_q};
            `FLG_CMD_STATUS_INPUT: cmd_rdata_o <= {24'h0, st_in_q};
            `FLG_CMD_STATUS_TEMP: cmd_rdata_o <= {24'h0, st_tmp_q};
            `FLG_CMD_READ_VIN: cmd_rdata_o <= {16'h0, tel_q.vin};
            `FLG_CMD_READ_VOUT: cmd_rdata_o <= {16'h0, tel_q.vout};
            `FLG_CMD_READ_IOUT: cmd_rdata_o <= {16'h0, tel_q.iout};
            `FLG_CMD_READ_TEMP: cmd_rdata_o <= {16'h0, tel_q.temp};
            `FLG_CMD_LOOP_GAIN: cmd_rdata_o <= loop_gain_config_q;
            `FLG_CMD_GAIN_RED: cmd_rdata_o <= {16'h0, gain_reduction_config_q};
            `FLG_CMD_AVG_OC_LIM: cmd_rdata_o <= {16'h0, avg_oc_q};
            `FLG_CMD_AVG_RC_LIM: cmd_rdata_o <= {16'h0, avg_rc_q};
            default: cmd_rdata_o <= 32'h0;
          endcase
        end
        FLG_ANS: begin
          cmd_rvalid_o <= 1'b1;
          cst_q <= FLG_IDLE;
        end
        default: cst_q <= FLG_IDLE;
      endcase
    end
  end
endmodule

// ==== flg_fault_loop_asserts.sv ====
// Port-level checker of the fault-protect and loop-gain block, bound to its top module.
// Assumes the average current limits and fault responses keep their reset values.
`timescale 1ns/10ps
`include "flg_consts.svh"
module flg_fault_loop_asserts import flg_pkg::*; #(
  parameter int LOW_ERR_CYCLES = 64,
  parameter logic signed [15:0] PEAK_LIMIT = 16'sh00C8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cycle_i,
  input wire flg_meas_s meas_i,
  input wire logic signed [15:0] inst_cur_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_rvalid_o,
  input wire logic cmd_ack_o,
  input wire logic inhibit_o,
  input wire logic alert_o,
  input wire logic signed [31:0] pw_corr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] oc_cnt_q;
  logic over_c;
  // Counts consecutive over-limit cycles, saturating so a long overload never wraps.
  assign over_c = meas_i.iout > `FLG_AVG_OC_RST;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_cnt_q <= 5'h00;
    end else if (cycle_i) begin
      oc_cnt_q <= !over_c ? 5'h00 : (oc_cnt_q == 5'h1F ? oc_cnt_q : oc_cnt_q + 5'h01);
    end
  end
  ack_after_write_a: assert property (cmd_wr_i |=> cmd_ack_o)
    else $error("write not acknowledged");
  read_latency_a: assert property (cmd_rd_i |-> ##2 cmd_rvalid_o)
    else $error("read answer late");
  rvalid_pulse_a: assert property (cmd_rvalid_o |=> !cmd_rvalid_o)
    else $error("read valid longer than one cycle");
  oc_trip_a: assert property (cycle_i && over_c && oc_cnt_q == 5'h0F
    |-> ##2 alert_o && inhibit_o)
    else $error("overcurrent trip missing");
  oc_hold_off_a: assert property (!alert_o && cycle_i && over_c && oc_cnt_q < 5'h0F
    |-> ##2 !alert_o)
    else $error("overcurrent trip too early");
  rc_trip_a: assert property (cycle_i && meas_i.iout < `FLG_AVG_RC_RST
    |-> ##2 alert_o)
    else $error("reverse current trip missing");
  peak_trip_a: assert property (inst_cur_i > PEAK_LIMIT |-> ##[1:2] alert_o)
    else $error("peak current trip missing");
  corr_hold_a: assert property (!cycle_i |=> $stable(pw_corr_o))
    else $error("correction changed outside a cycle strobe");
  input_guard_a: assert property ($fell(rst_i) |-> inhibit_o)
    else $error("conversion allowed before first input sample");
  cover property (cycle_i && over_c && oc_cnt_q == 5'h0F);
  cover property (cycle_i && meas_i.iout < `FLG_AVG_RC_RST);
  cover property (cmd_rvalid_o);
endmodule
bind flg_fault_loop flg_fault_loop_asserts #(
  .LOW_ERR_CYCLES(LOW_ERR_CYCLES),
  .PEAK_LIMIT(PEAK_LIMIT)
) chk (
  .clk_i(clk_i), .rst_i(rst_i), .cycle_i(cycle_i), .meas_i(meas_i), .inst_cur_i(inst_cur_i),
  .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_rvalid_o(cmd_rvalid_o), .cmd_ack_o(cmd_ack_o),
  .inhibit_o(inhibit_o), .alert_o(alert_o), .pw_corr_o(pw_corr_o)
);

// ==== flg_fault_loop_tb.sv ====
// Self-checking bench of the fault-protect and loop-gain block.
// Assumes the host model drives the command port and the checker is bound.
`timescale 1ns/10ps
`include "flg_consts.svh"
module flg_fault_loop_tb import flg_pkg::*;;
  localparam logic signed [15:0] PEAK = 16'sh00C8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cycle_i = 1'b0;
  logic power_good_pin_i = 1'b0;
  logic signed [15:0] err_i = 16'sh0000;
  logic signed [15:0] inst_cur_i = 16'sh0000;
  flg_meas_s meas_i = '0;
  logic wr, rd, ack, rvalid, inhibit, alert;
  logic [7:0] code;
  logic [31:0] wdata, rdata, got;
  logic signed [31:0] pw_corr;
  logic signed [15:0] vt[5] = '{16'sd300, 16'sd501, 16'sd500, 16'sd99, 16'sd100};
  function automatic logic exp_inhibit(input int v);
    return v > 500 || v < 100;
  endfunction
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int p, e, r, ig, s, t;
  always #2.5 clk_i = ~clk_i;
  // A short low-error period keeps the gain-reduction scenario brief.
  flg_fault_loop #(.LOW_ERR_CYCLES(4), .PEAK_LIMIT(PEAK)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .cycle_i(cycle_i), .meas_i(meas_i), .err_i(err_i), .inst_cur_i(inst_cur_i),
    .power_good_pin_i(power_good_pin_i), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code),
    .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid), .cmd_ack_o(ack),
    .inhibit_o(inhibit), .alert_o(alert), .pw_corr_o(pw_corr));
  flg_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .ack_i(ack),
    .wr_o(wr), .rd_o(rd), .code_o(code), .wdata_o(wdata));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    tick(3);
    rst_i = 1'b0;
  endtask
  // Strobes are four clocks apart so every trip has settled on the alert before the next.
  task automatic strobe(input logic signed [15:0] v, input logic signed [15:0] io,
                        input logic signed [15:0] er);
    @(posedge clk_i) #1;
    cycle_i = 1'b1;
    meas_i.vin = v;
    meas_i.iout = io;
    err_i = er;
    @(posedge clk_i) #1;
    cycle_i = 1'b0;
    tick(2);
  endtask
  initial begin
    void'($urandom(32'h87EB5A34));
    do_reset();
    host.rd(`FLG_CMD_LOOP_GAIN, got);
    check("loop_gain_config", got, 32'h5050010E);
    host.wr(`FLG_CMD_VIN_OV_FLT, 32'h1F4);
    host.wr(`FLG_CMD_VIN_UV_FLT, 32'h64);
    foreach (vt[i]) begin
      strobe(vt[i], 16'sd0, 16'sd0);
      check("inhibit_o", inhibit, exp_inhibit(vt[i]));
    end
    host.rd(`FLG_CMD_STATUS_INPUT, got);
    check("status_input", got[7:0], 8'h90);
    check("alert_o", alert, 1'b1);
    host.wr(`FLG_CMD_STATUS_INPUT, 32'hFF);
    tick(2);
    check("alert_o", alert, 1'b0);
    for (int i = 0; i < 32; i++) begin
      strobe(16'sd300, i == 15 ? 16'sd101 : 16'($urandom_range(400, 102)), 16'sd0);
      check("alert_o", alert, i == 31);
    end
    check("inhibit_o", inhibit, 1'b1);
    host.rd(`FLG_CMD_STATUS_IOUT, got);
    check("status_iout", got[7:0], 8'h80);
    host.wr(`FLG_CMD_STATUS_IOUT, 32'hFF);
    strobe(16'sd300, -16'sd99, 16'sd0);
    check("alert_o", alert, 1'b0);
    strobe(16'sd300, -16'sd100, 16'sd0);
    check("alert_o", alert, 1'b1);
    host.rd(`FLG_CMD_STATUS_IOUT, got);
    check("status_iout", got[7:0], 8'h10);
    host.rd(`FLG_CMD_READ_IOUT, got);
    check("read_iout", got[15:0], 16'hFF9C);
    host.rd(8'h00, got);
    check("unknown_read", got, 32'h0);
    host.wr(`FLG_CMD_STATUS_IOUT, 32'hFF);
    strobe(16'sd300, 16'sd0, 16'sd0);
    inst_cur_i = PEAK;
    tick(3);
    check("alert_o", alert, 1'b0);
    inst_cur_i = PEAK + 16'sd1;
    tick(1);
    inst_cur_i = 16'sd0;
    tick(2);
    check("alert_o", alert, 1'b1);
    host.wr(`FLG_CMD_VOUT_UV_FLT, 32'h64);
    host.wr(`FLG_CMD_OT_FLT, 32'h64);
    meas_i.vout = 16'sd50;
    meas_i.temp = 16'sd150;
    strobe(16'sd300, 16'sd0, 16'sd0);
    host.rd(`FLG_CMD_STATUS_VOUT, got);
    check("status_vout", got[7:0], 8'h00);
    host.rd(`FLG_CMD_STATUS_TEMP, got);
    check("status_temp", got[7:0], 8'h80);
    power_good_pin_i = 1'b1;
    repeat (2) strobe(16'sd300, 16'sd0, 16'sd0);
    host.rd(`FLG_CMD_STATUS_VOUT, got);
    check("status_vout", got[7:0], 8'h10);
    host.rd(`FLG_CMD_STATUS_BYTE, got);
    check("status_byte", got[7:0], 8'h54);
    do_reset();
    p = $urandom_range(1000, 1);
    e = $urandom_range(200, 1);
    r = $urandom_range(255, 1);
    ig = $urandom_range(100, 1);
    host.wr(`FLG_CMD_LOOP_GAIN, {16'h0000, 16'(p)});
    strobe(16'sd300, 16'sd0, 16'(e));
    check("pw_corr_o", pw_corr, 32'(e * p));
    host.wr(`FLG_CMD_LOOP_GAIN, {8'h00, 8'(r), 16'(p)});
    strobe(16'sd300, 16'sd0, 16'sd0);
    check("pw_corr_o", pw_corr, 32'(-((e * p * r) >>> 8)));
    host.wr(`FLG_CMD_LOOP_GAIN, {8'(ig), 8'h00, 16'(p)});
    strobe(16'sd300, 16'sd0, 16'(e));
    strobe(16'sd300, 16'sd0, 16'sd0);
    check("pw_corr_o", pw_corr, 32'(e * ig));
    do_reset();
    t = $urandom_range(500, 50);
    s = $urandom_range(3, 1);
    e = $urandom_range(t, 1);
    host.wr(`FLG_CMD_LOOP_GAIN, {16'h0000, 16'(p)});
    host.wr(`FLG_CMD_GAIN_RED, {18'h0, 2'(s), 12'(t)});
    repeat (8) strobe(16'sd300, 16'sd0, 16'(e));
    check("pw_corr_o", pw_corr, 32'(e * (p >> s)));
    strobe(16'sd300, 16'sd0, 16'(t + 1));
    check("pw_corr_o", pw_corr, 32'((t + 1) * p));
    repeat (4) strobe(16'sd300, 16'sd0, 16'(e));
    check("pw_corr_o", pw_corr, 32'(e * p));
    strobe(16'sd300, 16'sd0, 16'(e));
    check("pw_corr_o", pw_corr, 32'(e * (p >> s)));
    check("host_timeouts", host.misses, 32'h0);
    close_out();
  end
endmodule

// ==== flg_host_model.sv ====
// Host side of the command port: single write and read transactions.
// Assumes strobes are one-cycle pulses and the device answers within a few clocks.
`timescale 1ns/10ps
module flg_host_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic ack_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] code_o,
  output logic [31:0] wdata_o
);
  // Counts answers that never came, so the bench can report a silent port.
  int misses = 0;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    code_o = 8'h00;
    wdata_o = 32'h0;
  end
  // Data is inverted after the strobe so a stale value can never pass as a fresh one.
  task automatic wr(input logic [7:0] c, input logic [31:0] d);
    int n;
    @(posedge clk_i) #1;
    wr_o = 1'b1;
    code_o = c;
    wdata_o = d;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
    wdata_o = ~d;
    n = 0;
    while (!ack_i && n < 4) begin
      @(posedge clk_i) #1;
      n++;
    end
    if (!ack_i) begin
      misses++;
    end
  endtask
  task automatic rd(input logic [7:0] c, output logic [31:0] d);
    int n;
    @(posedge clk_i) #1;
    rd_o = 1'b1;
    code_o = c;
    @(posedge clk_i) #1;
    rd_o = 1'b0;
    n = 0;
    while (!rvalid_i && n < 4) begin
      @(posedge clk_i) #1;
      n++;
    end
    if (!rvalid_i) begin
      misses++;
    end
    d = rdata_i;
  endtask
endmodule

// ==== flg_pkg.sv ====
// Types shared by the fault-protect and loop-gain block.
// Assumes the includer also pulls in flg_consts.svh for numbers.
package flg_pkg;
  typedef struct packed {
    logic signed [15:0] vin;
    logic signed [15:0] vout;
    logic signed [15:0] iout;
    logic signed [15:0] temp;
  } flg_meas_s;
  typedef struct packed {
    logic ov_flt;
    logic ov_wrn;
    logic uv_wrn;
    logic uv_flt;
  } flg_cmp_s;
  typedef enum logic [2:0] {
    FLG_IDLE = 3'b001,
    FLG_WAIT = 3'b010,
    FLG_ANS = 3'b100
  } flg_cmd_e;
endpackage
